// ===== msp_cfg.svh
/*
 * Constants of the speed-pulse and fault-response block: register offsets,
 * reset values, field codes and timing figures.
 * Assumes a 100 MHz clock and an APB slave with byte addresses.
 */
`ifndef MSP_CFG_SVH
`define MSP_CFG_SVH

// Register byte offsets
`define MSP_ADDR_CONFIG    8'h00
`define MSP_ADDR_LEVELS    8'h04
`define MSP_ADDR_CONTROL   8'h08
`define MSP_ADDR_STATUS    8'h0C

// Reset values
`define MSP_CONFIG_RST     32'h0000_0000
`define MSP_LEVELS_RST     32'h0000_0000

// Control register bit positions
`define MSP_CTRL_RUN       0
`define MSP_CTRL_CLR       1

// Field codes
`define MSP_HALT_SPINDOWN  3'h4
`define MSP_PIN_KEEP       2'h0
`define MSP_PIN_HIZ        2'h1
`define MSP_PIN_LOW        2'h2
`define MSP_OL_BOTH        2'h0
`define MSP_OL_CLOSED      2'h1
`define MSP_OL_FIRST       2'h2
`define MSP_DIV_EVERY      4'h0
`define MSP_LOCK_REPORT    4'h8

// Commutations per electrical cycle
`define MSP_COMM_PER_ELEC  6'h03

// Timing
`define MSP_CLK_PERIOD_NS  10
`define MSP_LOCK_RETRY_NS  1000000
`define MSP_SPIN_STEP_NS   1000
`define MSP_SPIN_STEP_CYC  (`MSP_SPIN_STEP_NS / `MSP_CLK_PERIOD_NS)
`define MSP_LOCK_RETRY_CYC (`MSP_LOCK_RETRY_NS / `MSP_CLK_PERIOD_NS)

`endif

// ===== msp_pkg.sv
/*
 * Types of the speed-pulse and fault-response block.
 * Assumes msp_cfg.svh supplies the numeric constants.
 */
package msp_pkg;

    // Drive sequencing states
    typedef enum logic [1:0] {
        MSP_IDLE  = 2'b00,
        MSP_DRIVE = 2'b01,
        MSP_SPIN  = 2'b10
    } msp_state_e;

    // What the bridge is told to do
    typedef enum logic [2:0] {
        MSP_BR_DRIVE  = 3'b000,
        MSP_BR_FLOAT  = 3'b001,
        MSP_BR_RECIRC = 3'b010,
        MSP_BR_HSBRK  = 3'b011,
        MSP_BR_LSBRK  = 3'b100
    } msp_bridge_e;

    // Configuration register layout
    typedef struct packed {
        logic [10:0] rsvd;
        logic        shuntDis;
        logic        dsDis;
        logic        bootDis;
        logic [3:0]  lockAction;
        logic [1:0]  faultPin;
        logic [1:0]  stopPin;
        logic [1:0]  olSel;
        logic [3:0]  divider;
        logic        enableMode;
        logic [2:0]  haltSel;
    } msp_config_s;

    // Level register layout
    typedef struct packed {
        logic [7:0] rsvd;
        logic [7:0] bemfThr;
        logic [7:0] spinThr;
        logic [7:0] target;
    } msp_levels_s;

    // Fault detector inputs
    typedef struct packed {
        logic mainUv;
        logic avddPor;
        logic gateUv;
        logic bootUv;
        logic dsOc;
        logic shuntOc;
        logic lock;
    } msp_faults_s;

endpackage

// ===== msp_core.sv
/*
 * Speed-pulse generator, active spin-down sequencer and fault response of a
 * sensorless three-phase driver, with an APB register slave.
 * Assumes synchronous detector inputs, one commutation pulse per step from
 * the commutation logic, and an external pull-up on the speed pulse pin.
 */
`timescale 1ns/1ns
`include "msp_cfg.svh"

// Behaviour
// - Halt selection 100b picks active spin-down on a stop command.
// - Spin-down lowers duty to its threshold, then floats every bridge transistor.
// - Enable mode 1: speed pulses active only while the motor is driven.
// - Enable mode 0: speed pulses continue until back-EMF falls below threshold.
// - Divider 0000b toggles the pulse once per commutation.
// - Other divider values give one pulse per N electrical cycles, N 1..15.
// - Open-loop select 00b: pulses in both open and closed loop.
// - Open-loop select 01b: pin released during open loop.
// - Open-loop select 10b: pulses in open loop only on first start-up.
// - Stop setting 00b: pulses continue until stop, then level held.
// - Stop setting 01b: pin released once the motor is judged stopped.
// - Stop setting 10b: pin driven low once the motor is stopped.
// - Fault setting 00b: pulses continue through faults, last level held.
// - Fault setting 01b: pin released while a fault is reported.
// - Fault setting 10b: pin driven low while a fault is reported.
// - Supply faults report, disable gates and logic, recover automatically.
// - Gate supply undervoltage reports, pulls gates low, latched until cleared.
// - Bootstrap, drain-source, shunt faults act only when not disabled, latched.
// - Lock actions 0-3 latch, 4-7 same actions retried after retry time.
// - Lock action 8 only reports; 9 to 15 ignore the lock.
module msp_core
    import msp_pkg::*;
#(
    parameter int unsigned LOCK_RETRY_CYC = `MSP_LOCK_RETRY_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Motor side inputs
    input  wire logic        commutationTick,
    input  wire logic        openLoop,
    input  wire logic        wakeEvent,
    input  wire logic [7:0]  backemfLevel,
    input  wire msp_faults_s faults,
    // Pin and bridge outputs
    output logic             speedPulseOut,
    output logic             speedPulseOe,
    output logic             faultIndicatorN,
    output msp_bridge_e      bridgeMode,
    output logic [7:0]       dutyOut,
    output logic             gateEnable,
    output logic             logicEnable
);

    localparam logic [15:0] SPIN_STEP = 16'(`MSP_SPIN_STEP_CYC);
    localparam logic [23:0] RETRY_END = 24'(LOCK_RETRY_CYC - 1);

    msp_config_s cfg_q;
    msp_levels_s lvl_q;
    msp_state_e  state_q;
    logic        run_q, clr_q;
    logic [7:0]  duty_q;
    logic [15:0] stepCnt_q;
    logic        gateLatch_q, lockFlag_q;
    logic [23:0] retryCnt_q;
    logic [5:0]  phaseCnt_q;
    logic        level_q, firstStart_q, olPrev_q;
    logic        setup, access, mapped, wr;
    logic [31:0] rdMux;
    logic        supplyFault, gateSet, lockActing, lockRetryMode, faultNow;
    logic        driving, pulseActive, stepTick, olHide, toggle;
    logic [5:0]  period, half;
    msp_bridge_e bridgeNext;

    // Bus phases; one setup cycle, access answered at once
    assign setup  = psel & ~penable;
    assign access = psel & penable & pready;
    assign mapped = (paddr == `MSP_ADDR_CONFIG) | (paddr == `MSP_ADDR_LEVELS) |
                    (paddr == `MSP_ADDR_CONTROL) | (paddr == `MSP_ADDR_STATUS);
    assign wr     = access & pwrite & mapped;

    // Read data mux
    always_comb begin
        case (paddr)
            `MSP_ADDR_CONFIG:  rdMux = cfg_q;
            `MSP_ADDR_LEVELS:  rdMux = lvl_q;
            `MSP_ADDR_CONTROL: rdMux = {31'h0000_0000, run_q};
            `MSP_ADDR_STATUS:  rdMux = {24'h00_0000, ~faultIndicatorN, level_q, firstStart_q,
                                        state_q, lockFlag_q, gateLatch_q, supplyFault};
            default:           rdMux = 32'h0000_0000;
        endcase
    end

    // Answer registered in setup so every output is a flop
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            prdata  <= setup ? rdMux : 32'h0000_0000;
        end
    end

    // Software registers; clear command is a one-cycle pulse
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_q <= `MSP_CONFIG_RST;
            lvl_q <= `MSP_LEVELS_RST;
            run_q <= 1'b0;
            clr_q <= 1'b0;
        end else begin
            clr_q <= wr & (paddr == `MSP_ADDR_CONTROL) & pwdata[`MSP_CTRL_CLR];
            if (wr && paddr == `MSP_ADDR_CONFIG) begin
                cfg_q <= {11'h000, pwdata[20:0]};
            end
            if (wr && paddr == `MSP_ADDR_LEVELS) begin
                lvl_q <= {8'h00, pwdata[23:0]};
            end
            if (wr && paddr == `MSP_ADDR_CONTROL) begin
                run_q <= pwdata[`MSP_CTRL_RUN];
            end
        end
    end

    // Fault classification
    assign supplyFault   = faults.mainUv | faults.avddPor;
    assign gateSet       = faults.gateUv | (faults.bootUv & ~cfg_q.bootDis) |
                           (faults.dsOc & ~cfg_q.dsDis) | (faults.shuntOc & ~cfg_q.shuntDis);
    assign lockActing    = lockFlag_q & ~cfg_q.lockAction[3];
    assign lockRetryMode = cfg_q.lockAction[3:2] == 2'b01;
    assign faultNow      = supplyFault | gateLatch_q | lockFlag_q;

    // Gate driver fault latch; a new fault beats the clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gateLatch_q <= 1'b0;
        end else begin
            gateLatch_q <= gateSet | (gateLatch_q & ~clr_q);
        end
    end

    // Lock fault flag with latched or retried recovery
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lockFlag_q <= 1'b0;
            retryCnt_q <= 24'h00_0000;
        end else begin
            if (faults.lock && cfg_q.lockAction <= `MSP_LOCK_REPORT) begin
                lockFlag_q <= 1'b1;
            end else if (clr_q) begin
                lockFlag_q <= 1'b0;
            end else if (lockFlag_q && lockRetryMode && retryCnt_q == RETRY_END) begin
                lockFlag_q <= 1'b0;
            end
            if (lockFlag_q && lockRetryMode && retryCnt_q != RETRY_END) begin
                retryCnt_q <= retryCnt_q + 24'h00_0001;
            end else begin
                retryCnt_q <= 24'h00_0000;
            end
        end
    end

    // Spin-down step pacing; slow ramp keeps the motor in sync
    assign stepTick = (state_q == MSP_SPIN) && (stepCnt_q == SPIN_STEP - 16'h0001);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stepCnt_q <= 16'h0000;
        end else if (state_q != MSP_SPIN || stepTick) begin
            stepCnt_q <= 16'h0000;
        end else begin
            stepCnt_q <= stepCnt_q + 16'h0001;
        end
    end

    // Drive sequencer; supply loss drops it back to idle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= MSP_IDLE;
            duty_q  <= 8'h00;
        end else if (supplyFault) begin
            state_q <= MSP_IDLE;
            duty_q  <= 8'h00;
        end else begin
            case (state_q)
                MSP_IDLE: begin
                    if (run_q) begin
                        state_q <= MSP_DRIVE;
                        duty_q  <= lvl_q.target;
                    end
                end
                MSP_DRIVE: begin
                    duty_q <= lvl_q.target;
                    if (!run_q) begin
                        if (cfg_q.haltSel == `MSP_HALT_SPINDOWN) begin
                            state_q <= MSP_SPIN;
                        end else begin
                            state_q <= MSP_IDLE;
                            duty_q  <= 8'h00;
                        end
                    end
                end
                MSP_SPIN: begin
                    if (run_q) begin
                        state_q <= MSP_DRIVE;
                    end else if (stepTick) begin
                        if (duty_q > lvl_q.spinThr) begin
                            duty_q <= duty_q - 8'h01;
                        end else begin
                            state_q <= MSP_IDLE;
                            duty_q  <= 8'h00;
                        end
                    end
                end
                default: begin
                    state_q <= MSP_IDLE;
                end
            endcase
        end
    end

    // Bridge command, gate and logic enables
    assign driving = (state_q == MSP_DRIVE) || (state_q == MSP_SPIN);
    always_comb begin
        if (supplyFault || gateLatch_q) begin
            bridgeNext = MSP_BR_FLOAT;
        end else if (lockActing) begin
            bridgeNext = msp_bridge_e'({1'b0, cfg_q.lockAction[1:0]} + 3'h1);
        end else if (driving) begin
            bridgeNext = MSP_BR_DRIVE;
        end else begin
            bridgeNext = MSP_BR_FLOAT;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bridgeMode      <= MSP_BR_FLOAT;
            dutyOut         <= 8'h00;
            gateEnable      <= 1'b0;
            logicEnable     <= 1'b0;
            faultIndicatorN <= 1'b1;
        end else begin
            bridgeMode      <= bridgeNext;
            dutyOut         <= (bridgeNext == MSP_BR_DRIVE) ? duty_q : 8'h00;
            gateEnable      <= ~(supplyFault | gateLatch_q);
            logicEnable     <= ~supplyFault;
            faultIndicatorN <= ~faultNow;
        end
    end

    // Speed pulse period: 3 commutations per electrical cycle times divider
    assign pulseActive = driving | (~cfg_q.enableMode & (backemfLevel >= lvl_q.bemfThr));
    assign period = 6'(cfg_q.divider * `MSP_COMM_PER_ELEC);
    assign half   = period >> 1;
    assign toggle = commutationTick & pulseActive &
                    ((cfg_q.divider == `MSP_DIV_EVERY) ||
                     (phaseCnt_q == period - 6'h01) || (phaseCnt_q == half - 6'h01));

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phaseCnt_q <= 6'h00;
            level_q    <= 1'b0;
        end else begin
            if (commutationTick && pulseActive) begin
                phaseCnt_q <= (phaseCnt_q >= period - 6'h01) ? 6'h00 : phaseCnt_q + 6'h01;
            end
            if (toggle) begin
                level_q <= ~level_q;
            end
        end
    end

    // First start-up tracking; a wake event re-arms it over a clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            firstStart_q <= 1'b1;
            olPrev_q     <= 1'b0;
        end else begin
            olPrev_q <= openLoop;
            if (wakeEvent) begin
                firstStart_q <= 1'b1;
            end else if (driving && olPrev_q && !openLoop) begin
                firstStart_q <= 1'b0;
            end
        end
    end

    // Open-loop masking of the pin
    assign olHide = driving & openLoop &
                    ((cfg_q.olSel == `MSP_OL_CLOSED) ||
                     (cfg_q.olSel == `MSP_OL_FIRST && !firstStart_q));

    // Pin drive; fault setting wins over open loop and stop settings
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            speedPulseOut <= 1'b0;
            speedPulseOe  <= 1'b0;
        end else if (faultNow && cfg_q.faultPin == `MSP_PIN_HIZ) begin
            speedPulseOut <= 1'b0;
            speedPulseOe  <= 1'b0;
        end else if (faultNow && cfg_q.faultPin == `MSP_PIN_LOW) begin
            speedPulseOut <= 1'b0;
            speedPulseOe  <= 1'b1;
        end else if (olHide) begin
            speedPulseOut <= 1'b0;
            speedPulseOe  <= 1'b0;
        end else if (!pulseActive && cfg_q.stopPin == `MSP_PIN_HIZ) begin
            speedPulseOut <= 1'b0;
            speedPulseOe  <= 1'b0;
        end else if (!pulseActive && cfg_q.stopPin == `MSP_PIN_LOW) begin
            speedPulseOut <= 1'b0;
            speedPulseOe  <= 1'b1;
        end else begin
            speedPulseOut <= level_q;
            speedPulseOe  <= 1'b1;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_spin_entry;
        state_q == MSP_DRIVE && !run_q && cfg_q.haltSel == `MSP_HALT_SPINDOWN && !supplyFault
            |=> state_q == MSP_SPIN;
    endproperty
    a_spin_entry: assert property (p_spin_entry) else $error("spin-down not entered");

    property p_spin_exit;
        state_q == MSP_SPIN && stepTick && !run_q && duty_q <= lvl_q.spinThr && !supplyFault
            && !gateLatch_q && !gateSet && !lockFlag_q && !faults.lock
            |=> state_q == MSP_IDLE ##1 bridgeMode == MSP_BR_FLOAT && dutyOut == 8'h00;
    endproperty
    a_spin_exit: assert property (p_spin_exit) else $error("spin-down did not float");

    property p_div_every;
        cfg_q.divider == `MSP_DIV_EVERY && commutationTick && pulseActive
            |=> level_q != $past(level_q);
    endproperty
    a_div_every: assert property (p_div_every) else $error("no toggle per step");

    property p_ol_closed;
        !faultNow && driving && openLoop && cfg_q.olSel == `MSP_OL_CLOSED |=> !speedPulseOe;
    endproperty
    a_ol_closed: assert property (p_ol_closed) else $error("pin driven in open loop");

    property p_stop_low;
        !faultNow && !pulseActive && cfg_q.stopPin == `MSP_PIN_LOW
            |=> speedPulseOe && !speedPulseOut;
    endproperty
    a_stop_low: assert property (p_stop_low) else $error("pin not low at stop");

    property p_fault_hiz;
        faultNow && cfg_q.faultPin == `MSP_PIN_HIZ |=> !speedPulseOe;
    endproperty
    a_fault_hiz: assert property (p_fault_hiz) else $error("pin driven in fault");

    property p_fault_low;
        faultNow && cfg_q.faultPin == `MSP_PIN_LOW |=> speedPulseOe && !speedPulseOut;
    endproperty
    a_fault_low: assert property (p_fault_low) else $error("pin not low in fault");

    property p_supply;
        supplyFault |=> !gateEnable && !logicEnable && !faultIndicatorN && state_q == MSP_IDLE;
    endproperty
    a_supply: assert property (p_supply) else $error("supply fault not handled");

    property p_gate_uv;
        faults.gateUv |=> gateLatch_q ##1 !faultIndicatorN && !gateEnable;
    endproperty
    a_gate_uv: assert property (p_gate_uv) else $error("gate fault not latched");

    property p_lock_retry;
        lockFlag_q && lockRetryMode && retryCnt_q == RETRY_END && !faults.lock
            |=> !lockFlag_q;
    endproperty
    a_lock_retry: assert property (p_lock_retry) else $error("lock retry missed");

    property p_lock_ignore;
        faults.lock && cfg_q.lockAction > `MSP_LOCK_REPORT && !lockFlag_q && !clr_q
            |=> !lockFlag_q;
    endproperty
    a_lock_ignore: assert property (p_lock_ignore) else $error("ignored lock reported");

    c_spin_done: cover property (state_q == MSP_SPIN ##1 state_q == MSP_IDLE);
    c_lock_retry: cover property (lockFlag_q && lockRetryMode ##1 !lockFlag_q);
    c_fault_low: cover property (faultNow && cfg_q.faultPin == `MSP_PIN_LOW);
    c_first_hide: cover property (olHide && cfg_q.olSel == `MSP_OL_FIRST);

endmodule

// ===== msp_motor_model.sv
/* Motor and pull-up model at the far side of the speed pulse pin.
   Assumes the bench sets rotation; commutation gap is fixed at five cycles. */
`timescale 1ns/1ns
module msp_motor_model (
    // Clock and control
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       spinning,
    // Pin from the device
    input  wire logic       pinLevel,
    input  wire logic       pinOe,
    // Motor side
    output logic            tick,
    output logic [7:0]      backemf,
    output logic            pinWire
);
    logic [2:0] gap_q;
    // One commutation every five cycles, so pin edges fall between ticks
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gap_q <= 3'h0;
            tick  <= 1'b0;
        end else begin
            gap_q <= (gap_q == 3'h4) ? 3'h0 : gap_q + 3'h1;
            tick  <= spinning && (gap_q == 3'h4);
        end
    end
    // Back-EMF present only while the rotor turns
    assign backemf = spinning ? 8'h80 : 8'h00;
    // Released pin reads high through the pull-up
    assign pinWire = pinOe ? pinLevel : 1'b1;
endmodule

// ===== motor_speed_pulse_and_fault_response_tb.sv
/* Bench of msp_core: registers, speed pulse, fault response, spin-down.
   Assumes msp_pkg, msp_cfg.svh and msp_motor_model compile first. */
`timescale 1ns/1ns
`include "msp_cfg.svh"
module motor_speed_pulse_and_fault_response_tb import msp_pkg::*; ;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr, rerr;
    logic        tick, openLoop, wakeEvent, spinning, pinWire, spO, spOe;
    logic        fIndN, gateEn, logicEn;
    logic [7:0]  paddr, bemf, duty;
    logic [31:0] pwdata, prdata, rdata;
    msp_faults_s faults;
    msp_bridge_e bridge;
    msp_config_s cfg;
    int          errCount, numChecks, ticks;

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    msp_core #(.LOCK_RETRY_CYC(8)) msp_core_i (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .commutationTick(tick), .openLoop(openLoop),
        .wakeEvent(wakeEvent), .backemfLevel(bemf), .faults(faults),
        .speedPulseOut(spO), .speedPulseOe(spOe), .faultIndicatorN(fIndN),
        .bridgeMode(bridge), .dutyOut(duty), .gateEnable(gateEn), .logicEnable(logicEn));
    msp_motor_model msp_motor_model_i (.clk(clk), .reset(reset), .spinning(spinning),
        .pinLevel(spO), .pinOe(spOe), .tick(tick), .backemf(bemf), .pinWire(pinWire));

    // Commutation count for the divider checks
    always @(posedge clk) if (tick === 1'b1) ticks <= ticks + 1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            errCount++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer; entered just after a rising edge, idle cycle after
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wcfg();
        apb(1'b1, `MSP_ADDR_CONFIG, 32'(cfg));
    endtask

    // Wait for the next level change on the pin; the watchdog bounds it
    task automatic edgeWait();
        logic v;
        v = pinWire;
        while (pinWire === v) begin
            @(posedge clk);
        end
    endtask

    // Commutations across one full pulse period; first two edges settle
    task automatic measure(input logic [3:0] div);
        int t0;
        edgeWait();
        edgeWait();
        t0 = ticks;
        edgeWait();
        edgeWait();
        chk(32'(ticks - t0), (div == 4'h0) ? 32'h2 : 32'h3 * div);
    endtask

    // Bridge action expected for a lock fault
    function automatic msp_bridge_e lockMode(input logic [3:0] a);
        if (a >= 4'h8) return MSP_BR_DRIVE;
        case (a[1:0])
            2'h0: return MSP_BR_FLOAT;
            2'h1: return MSP_BR_RECIRC;
            2'h2: return MSP_BR_HSBRK;
            default: return MSP_BR_LSBRK;
        endcase
    endfunction

    task automatic conclude();
        $display("checks %0d mismatches %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog well above the expected run of some 2000 cycles
    initial begin
        repeat (40000) @(posedge clk);
        errCount++;
        conclude();
    end

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        {psel, penable, pwrite, openLoop, wakeEvent} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        faults = '0;
        spinning = 1'b1;
        {errCount, numChecks, ticks} = '0;
        void'($urandom(32'h7C690793));
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        // Defaults, random write-back, unmapped address refused
        apb(1'b0, `MSP_ADDR_CONFIG, 32'h0);
        chk(rdata, `MSP_CONFIG_RST);
        cfg = msp_config_s'($urandom);
        cfg.rsvd = '0;
        wcfg();
        apb(1'b0, `MSP_ADDR_CONFIG, 32'h0);
        chk(rdata, 32'(cfg));
        apb(1'b0, 8'h10, 32'h0);
        chk(32'(rerr), 32'h1);
        chk(rdata, 32'h0);
        $display("done: registers");
        // Open-loop hiding, both loops, first start-up only
        cfg = '0;
        cfg.enableMode = 1'b1;
        cfg.olSel = `MSP_OL_CLOSED;
        wcfg();
        apb(1'b1, `MSP_ADDR_CONTROL, 32'h1);
        openLoop <= 1'b1;
        repeat (4) @(posedge clk);
        chk({spOe, pinWire}, 2'b01);
        cfg.olSel = `MSP_OL_BOTH;
        wcfg();
        measure(4'h0);
        cfg.olSel = `MSP_OL_FIRST;
        wcfg();
        wakeEvent <= 1'b1;
        @(posedge clk);
        wakeEvent <= 1'b0;
        measure(4'h0);
        openLoop <= 1'b0;
        repeat (4) @(posedge clk);
        openLoop <= 1'b1;
        repeat (4) @(posedge clk);
        chk({spOe, pinWire}, 2'b01);
        openLoop <= 1'b0;
        // Divider corners with one random value between, rising order
        cfg.olSel = `MSP_OL_BOTH;
        for (int i = 0; i < 3; i++) begin
            cfg.divider = (i == 0) ? 4'h0 : (i == 1) ? 4'($urandom_range(1, 14)) : 4'hF;
            wcfg();
            measure(cfg.divider);
        end
        $display("done: open loop and divider");
        // Disabled overcurrent ignored; gate supply fault latched
        cfg = '0;
        cfg.faultPin = `MSP_PIN_LOW;
        {cfg.bootDis, cfg.dsDis, cfg.shuntDis} = 3'h7;
        wcfg();
        {faults.bootUv, faults.dsOc, faults.shuntOc} <= 3'h7;
        repeat (4) @(posedge clk);
        chk(32'(fIndN), 32'h1);
        faults.gateUv <= 1'b1;
        repeat (4) @(posedge clk);
        faults.gateUv <= 1'b0;
        repeat (4) @(posedge clk);
        chk({fIndN, gateEn, spOe, spO}, 4'b0010);
        apb(1'b0, `MSP_ADDR_STATUS, 32'h0);
        chk({rdata[7], rdata[2:0]}, 4'hA);
        apb(1'b1, `MSP_ADDR_CONTROL, 32'h3);
        repeat (4) @(posedge clk);
        chk({fIndN, gateEn}, 2'b11);
        cfg.faultPin = `MSP_PIN_HIZ;
        cfg.dsDis = 1'b0;
        wcfg();
        repeat (4) @(posedge clk);
        chk({fIndN, gateEn, spOe, pinWire}, 4'b0001);
        faults.dsOc <= 1'b0;
        apb(1'b1, `MSP_ADDR_CONTROL, 32'h3);
        // Supply fault recovers by itself
        faults <= msp_faults_s'($urandom_range(0, 1) ? 7'h40 : 7'h20);
        repeat (3) @(posedge clk);
        chk({fIndN, gateEn, logicEn}, 3'b000);
        faults <= '0;
        repeat (3) @(posedge clk);
        chk({fIndN, gateEn, logicEn}, 3'b111);
        $display("done: gate and supply faults");
        // Lock actions 0 to 9, then a random ignored one; retry versus latch
        for (int a = 0; a < 11; a++) begin
            cfg = '0;
            cfg.lockAction = (a == 10) ? 4'($urandom_range(9, 15)) : 4'(a);
            wcfg();
            faults.lock <= 1'b1;
            repeat (4) @(posedge clk);
            chk(32'(bridge), 32'(lockMode(cfg.lockAction)));
            chk(32'(fIndN), 32'(cfg.lockAction > 4'h8));
            faults.lock <= 1'b0;
            repeat (14) @(posedge clk);
            chk(32'(fIndN), 32'(a > 3 && a != 8));
            apb(1'b1, `MSP_ADDR_CONTROL, 32'h3);
            repeat (12) @(posedge clk);
        end
        $display("done: lock actions");
        // Spin-down steps duty to threshold, then floats
        cfg = '0;
        cfg.haltSel = `MSP_HALT_SPINDOWN;
        wcfg();
        apb(1'b1, `MSP_ADDR_LEVELS, 32'h0000_1C20);
        repeat (4) @(posedge clk);
        chk(duty, 8'h20);
        apb(1'b1, `MSP_ADDR_CONTROL, 32'h0);
        repeat (250) @(posedge clk);
        chk({bridge, duty}, {MSP_BR_DRIVE, 8'h1E});
        repeat (300) @(posedge clk);
        chk({bridge, duty}, {MSP_BR_FLOAT, 8'h00});
        // Stopped rotor: pin low, then released; back-EMF revives pulses
        spinning <= 1'b0;
        cfg.stopPin = `MSP_PIN_LOW;
        wcfg();
        apb(1'b1, `MSP_ADDR_LEVELS, 32'h0040_1C20);
        repeat (4) @(posedge clk);
        chk({spOe, spO}, 2'b10);
        cfg.stopPin = `MSP_PIN_HIZ;
        wcfg();
        repeat (4) @(posedge clk);
        chk({spOe, pinWire}, 2'b01);
        spinning <= 1'b1;
        measure(4'h0);
        $display("done: spin-down and stop");
        conclude();
    end
endmodule
